// ===== shared/pac_pkg.sv
// constants and types for the packed ascii codec
`default_nettype none
package pac_pkg;
    localparam int          BYTE_W       = 8;
    localparam int          CHAR_W       = 6;
    localparam int          HOLD_W       = 24;
    localparam int          SWAP_W       = 32;
    localparam int          IDX_W        = 2;
    localparam int          CNT_W        = 3;
    localparam int          FIFO_DEPTH   = 16;
    localparam int          FIFO_WIDTH   = BYTE_W + 1;
    localparam logic [1:0]  PACK_LAST    = 2'h3;
    localparam logic [1:0]  UNPACK_LAST  = 2'h2;
    localparam logic [1:0]  SWAP_LAST    = 2'h3;
    localparam logic [2:0]  PACK_OUT     = 3'h3;
    localparam logic [2:0]  UNPACK_OUT   = 3'h4;
    localparam logic [23:0] SPACE_GROUP  = 24'h820820;
    localparam logic [31:0] HOLD_RESET   = {8'h00, SPACE_GROUP};
    localparam logic [1:0]  MODE_RESET   = 2'h0;

    typedef enum logic [1:0] {
        PAC_PACK   = 2'b00,
        PAC_UNPACK = 2'b01,
        PAC_SWAP   = 2'b10
    } pac_mode_t;

    typedef enum logic {
        PAC_COLLECT = 1'b0,
        PAC_EMIT    = 1'b1
    } pac_state_t;
endpackage : pac_pkg
`default_nettype wire

// ===== shared/pac_stream_if.sv
// byte stream with last marker between codec and fifo
`timescale 1ns/1ps
`default_nettype none
interface pac_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    logic         last;
    modport src (output valid, output data, output last, input ready);
    modport snk (input valid, input data, input last, output ready);
endinterface : pac_stream_if
`default_nettype wire

// ===== src/pac_fifo.sv
// output fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pac_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic     clk,
    input  wire logic     rst_n,
    pac_stream_if.snk     wr,
    pac_stream_if.src     rd
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wrPtr_q;
    logic [AW:0]      rdPtr_q;
    wire              empty = (wrPtr_q == rdPtr_q);
    wire              full  = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) &&
                              (wrPtr_q[AW] != rdPtr_q[AW]);
    wire              doWr  = wr.valid && !full;
    wire              doRd  = rd.ready && !empty;

    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign {rd.last, rd.data} = mem_q[rdPtr_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (doWr) begin
            mem_q[wrPtr_q[AW-1:0]] <= {wr.last, wr.data};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_q + (AW+1)'(doWr);
            rdPtr_q <= rdPtr_q + (AW+1)'(doRd);
        end
    end
endmodule : pac_fifo
`default_nettype wire

// ===== src/pac_codec.sv
// packed ascii codec: pack, unpack and float byte reversal
// Behaviour
// - packing keeps low six bits per character
// - four six-bit characters become three bytes
// - short final group padded with spaces
// - codes 00..3F map to ascii 40..5F,20..3F
// - unpack loads three bytes into 24-bit register
// - unpacked bit 6 is inverse of bit 5
// - unpacked bit 7 forced to zero
// - float fields sent with bytes reversed
`timescale 1ns/1ps
`default_nettype none
module pac_codec (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] mode,
    input  wire logic       inValid,
    input  wire logic [7:0] inData,
    input  wire logic       inLast,
    output logic            inReady,
    output logic            outValid,
    output logic [7:0]      outData,
    output logic            outLast,
    input  wire logic       outReady
);
    pac_pkg::pac_state_t state_q;
    pac_pkg::pac_state_t state_d;
    pac_pkg::pac_mode_t  mode_q;
    logic [31:0]         hold_q;
    logic [31:0]         hold_d;
    logic [1:0]          idx_q;
    logic [2:0]          oidx_q;
    logic [2:0]          emitN_q;
    logic [2:0]          emitN_d;
    logic                last_q;

    pac_stream_if #(.W(8)) push ();
    pac_stream_if #(.W(8)) pop ();

    // mode taken at the first byte of each group
    wire pac_pkg::pac_mode_t modeIn  = pac_pkg::pac_mode_t'(mode);
    wire pac_pkg::pac_mode_t curMode = (idx_q == 2'h0) ? modeIn : mode_q;
    wire       collecting = (state_q == pac_pkg::PAC_COLLECT);
    wire       accept     = collecting && inValid;
    wire [1:0] lastIdx    = (curMode == pac_pkg::PAC_UNPACK) ? pac_pkg::UNPACK_LAST :
                            (curMode == pac_pkg::PAC_PACK)   ? pac_pkg::PACK_LAST :
                                                               pac_pkg::SWAP_LAST;
    wire       groupDone  = accept && (inLast || idx_q == lastIdx);
    wire       pushDone   = push.valid && push.ready;
    wire       lastOut    = (oidx_q == emitN_q - 3'h1);

    // character slot for unpack, byte slot for pack
    wire [5:0] packedChar = hold_q[pac_pkg::HOLD_W-1-pac_pkg::CHAR_W*oidx_q -: pac_pkg::CHAR_W];
    wire [7:0] packByte   = hold_q[pac_pkg::HOLD_W-1-pac_pkg::BYTE_W*oidx_q -: pac_pkg::BYTE_W];
    wire [7:0] asciiChar  = {1'b0, ~packedChar[5], packedChar};
    wire [2:0] swapSel    = emitN_q - 3'h1 - oidx_q;
    wire [7:0] swapByte   = hold_q[pac_pkg::BYTE_W*swapSel +: pac_pkg::BYTE_W];
    wire [7:0] emitByte   = (mode_q == pac_pkg::PAC_PACK)   ? packByte :
                            (mode_q == pac_pkg::PAC_UNPACK) ? asciiChar : swapByte;

    assign inReady    = collecting;
    assign push.valid = (state_q == pac_pkg::PAC_EMIT);
    assign push.data  = emitByte;
    assign push.last  = last_q && lastOut;

    assign outValid   = pop.valid;
    assign outData    = pop.data;
    assign outLast    = pop.last;
    assign pop.ready  = outReady;

    // holding register fill and next state
    always_comb begin
        hold_d  = hold_q;
        state_d = state_q;
        emitN_d = emitN_q;
        if (accept) begin
            unique case (curMode)
                pac_pkg::PAC_PACK: begin
                    hold_d[pac_pkg::HOLD_W-1-pac_pkg::CHAR_W*idx_q -: pac_pkg::CHAR_W] =
                        inData[5:0];
                end
                pac_pkg::PAC_UNPACK: begin
                    hold_d[pac_pkg::HOLD_W-1-pac_pkg::BYTE_W*idx_q -: pac_pkg::BYTE_W] =
                        inData;
                end
                default: begin
                    hold_d[pac_pkg::BYTE_W*idx_q +: pac_pkg::BYTE_W] = inData;
                end
            endcase
        end
        if (groupDone) begin
            state_d = pac_pkg::PAC_EMIT;
            unique case (curMode)
                pac_pkg::PAC_PACK:   emitN_d = pac_pkg::PACK_OUT;
                pac_pkg::PAC_UNPACK: emitN_d = pac_pkg::UNPACK_OUT;
                default:             emitN_d = {1'b0, idx_q} + 3'h1;
            endcase
        end
        if (pushDone && lastOut) begin
            state_d = pac_pkg::PAC_COLLECT;
            hold_d  = pac_pkg::HOLD_RESET;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= pac_pkg::PAC_COLLECT;
            mode_q  <= pac_pkg::pac_mode_t'(pac_pkg::MODE_RESET);
            hold_q  <= pac_pkg::HOLD_RESET;
            emitN_q <= '0;
        end else begin
            state_q <= state_d;
            hold_q  <= hold_d;
            emitN_q <= emitN_d;
            if (accept && idx_q == 2'h0) begin
                mode_q <= modeIn;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_q  <= '0;
            oidx_q <= '0;
            last_q <= 1'b0;
        end else begin
            if (groupDone) begin
                idx_q  <= '0;
                last_q <= inLast;
            end else if (accept) begin
                idx_q <= idx_q + 2'h1;
            end
            if (pushDone) begin
                oidx_q <= lastOut ? 3'h0 : oidx_q + 3'h1;
            end
        end
    end

    pac_fifo #(
        .WIDTH (pac_pkg::FIFO_WIDTH),
        .DEPTH (pac_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk   (clk),
        .rst_n (rst_n),
        .wr    (push),
        .rd    (pop)
    );
endmodule : pac_codec
`default_nettype wire

// ===== dv/pac_sink.sv
// output sink that stalls or accepts slowly
`timescale 1ns/1ps
`default_nettype none
module pac_sink (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic stall,
    input  wire logic slow,
    output logic      outReady
);
    logic phase_q;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) phase_q <= 1'b0;
        else phase_q <= !phase_q;
    assign outReady = !stall && (!slow || phase_q);
endmodule : pac_sink
`default_nettype wire

// ===== dv/pac_codec_checker.sv
// assertions on the codec ports
`timescale 1ns/1ps
`default_nettype none
module pac_codec_checker (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [1:0] mode,
    input wire logic       inValid,
    input wire logic [7:0] inData,
    input wire logic       inLast,
    input wire logic       inReady,
    input wire logic       outValid,
    input wire logic [7:0] outData,
    input wire logic       outLast,
    input wire logic       outReady
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic lastIn = inValid && inReady && inLast;
    hold_out_a: assert property (outValid && !outReady |=>
        outValid && $stable({outData, outLast})) else $error("stalled output moved");
    reset_idle_a: assert property ($rose(rst_n) |-> !outValid && inReady)
        else $error("not idle after reset");
    unpack_bit7_a: assert property (outValid && mode == 2'h1 |-> !outData[7])
        else $error("bit 7 set");
    unpack_bit6_a: assert property (outValid && mode == 2'h1 |->
        outData[6] == !outData[5]) else $error("bit 6 wrong");
    pack_refuse_a: assert property (lastIn && mode == 2'h0 |=> !inReady[*3])
        else $error("pack emit short");
    unpack_refuse_a: assert property (lastIn && mode == 2'h1 |=> !inReady[*4])
        else $error("unpack emit short");
    emit_push_a: assert property (lastIn |-> ##2 outValid)
        else $error("no output");
    swap_stall_a: assert property (lastIn && mode[1] |=> !inReady)
        else $error("swap not emitting");
    cover property (lastIn && mode == 2'h0);
    cover property (lastIn && mode == 2'h1);
    cover property (outValid && !outReady ##1 outValid && !outReady);
endmodule : pac_codec_checker
bind pac_codec pac_codec_checker chk (.clk, .rst_n, .mode, .inValid, .inData, .inLast,
    .inReady, .outValid, .outData, .outLast, .outReady);
`default_nettype wire

// ===== dv/pac_codec_test.sv
// self-checking bench for the packed ascii codec
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin fails++; \
    $display("wrong value at %0t: %h not %h", $time, a, b); end end
module pac_codec_test;
    typedef struct {logic [1:0] m; int n; logic [31:0] i; int k; logic [31:0] o;} pac_row_t;
    logic clk, rst_n, inValid, inLast, inReady, outValid, outLast, outReady, stall, slow;
    logic [1:0] mode;
    logic [7:0] inData, outData;
    logic [8:0] got[$];
    int         fails, nCompared, cycles;
    pac_row_t   rows[8] = '{
        '{2'h2, 2, 32'h12340000, 2, 32'h34120000},
        '{2'h0, 4, 32'h41424344, 3, 32'h0420C400},
        '{2'h0, 4, 32'hC1FF207F, 3, 32'h07F83F00},
        '{2'h0, 1, 32'h41000000, 3, 32'h06082000},
        '{2'h1, 3, 32'h0420C400, 4, 32'h41424344},
        '{2'h1, 3, 32'h82082000, 4, 32'h20202020},
        '{2'h1, 3, 32'h07F83F00, 4, 32'h413F203F},
        '{2'h3, 4, 32'hC3160000, 4, 32'h000016C3}};
    pac_codec DUT (.clk, .rst_n, .mode, .inValid, .inData, .inLast, .inReady, .outValid,
        .outData, .outLast, .outReady);
    pac_sink sink (.clk, .rst_n, .stall, .slow, .outReady);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (outValid && outReady) got.push_back({outLast, outData});
        cycles++;
        if (cycles == 5000) begin
            fails++;
            end_sim();
        end
    end
    task automatic put(logic [1:0] m, logic [7:0] d, logic l);
        @(negedge clk);
        mode = m;
        inData = d;
        inLast = l;
        inValid = 1'b1;
        while (inReady !== 1'b1) @(negedge clk);
    endtask : put
    task automatic run(pac_row_t r);
        for (int j = 0; j < r.n; j++) put(r.m, r.i[31-8*j -: 8], j == r.n - 1);
        @(negedge clk);
        inValid = 1'b0;
        while (got.size() < r.k) @(negedge clk);
        for (int j = 0; j < r.k; j++)
            `CHK(got[j], {j == r.k - 1, r.o[31-8*j -: 8]})
        got.delete();
        $display("row done at %0t", $time);
    endtask : run
    task automatic end_sim();
        $display("fails %0d compared %0d", fails, nCompared);
        if (fails == 0 && nCompared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    initial begin
        {rst_n, inValid, inLast, stall, slow, mode, inData} = '0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        `CHK({inReady, outValid}, 2'b10)
        slow = 1'b1;
        foreach (rows[r]) run(rows[r]);
        stall = 1'b1;
        fork
            begin
                for (int j = 0; j < 24; j++) put(2'h0, 8'(65 + j % 4), j == 23);
                @(negedge clk);
                inValid = 1'b0;
            end
            begin
                repeat (60) @(negedge clk);
                `CHK(inReady, 1'b0)
                stall = 1'b0;
            end
        join
        while (got.size() < 18) @(negedge clk);
        for (int j = 0; j < 18; j++)
            `CHK(got[j], {j == 17, 8'(24'h0420C4 >> (16 - 8 * (j % 3)))})
        got.delete();
        $display("fifo fill done at %0t", $time);
        stall = 1'b1;
        for (int j = 0; j < 3; j++) put(2'h1, 8'h04, j == 2);
        @(negedge clk);
        inValid = 1'b0;
        rst_n = 1'b0;
        @(negedge clk);
        `CHK({inReady, outValid}, 2'b10)
        rst_n = 1'b1;
        stall = 1'b0;
        run(rows[4]);
        $display("mid-run reset done at %0t", $time);
        end_sim();
    end
endmodule : pac_codec_test
`default_nettype wire
